// ==== verilog/pwr_seq_pkg.sv ====
package pwr_seq_pkg;
    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_ADDR = 8'h00;
    localparam logic [7:0] IDLE_TMO_ADDR = 8'h04;
    localparam logic [7:0] SLEEP_TMO_ADDR = 8'h08;
    localparam logic [7:0] OFF_TMO_ADDR = 8'h0C;
    localparam logic [7:0] WAKE_INT_ADDR = 8'h10;
    localparam logic [7:0] STATUS_ADDR = 8'h14;
    localparam logic [7:0] RADIO_ADDR = 8'h18;
    localparam logic [7:0] PERIPH_EN_ADDR = 8'h1C;

    // CTRL fields
    localparam int CTRL_AUTO_BIT = 0;
    localparam int CTRL_TIMED_BIT = 1;
    localparam int CTRL_FORCE_BIT = 2;
    localparam int CTRL_WAKE_BIT = 3;

    // Radio power-down bit positions
    localparam int RPD_TX = 0;
    localparam int RPD_RX = 1;
    localparam int RPD_PLL = 2;
    localparam int RPD_PA = 3;

    // Reset values
    localparam logic [31:0] CTRL_RST = 32'h0000_0001;
    localparam logic [31:0] IDLE_TMO_RST = 32'h0000_0400;
    localparam logic [31:0] SLEEP_TMO_RST = 32'h0000_1000;
    localparam logic [31:0] OFF_TMO_RST = 32'h0001_0000;
    localparam logic [31:0] WAKE_INT_RST = 32'h0001_0000;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    // Shared peripheral oscillator nominal rate
    localparam int PERIPH_OSC_KHZ = 128;

    typedef enum logic [2:0] {
        MODE_ACTIVE = 3'b000,
        MODE_IDLE = 3'b001,
        MODE_SLEEP = 3'b010,
        MODE_OFF = 3'b011,
        MODE_TIMED = 3'b100
    } pmode_e;
endpackage

// ==== verilog/power_mode_sequencer.sv ====
module power_mode_sequencer
    import pwr_seq_pkg::*;
#(
    parameter int NUM_PERIPH = 4,
    parameter int KSCAN_IDX = 0
) (
    input wire logic REF_CLK,
    input wire logic RESETN,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire logic [NUM_PERIPH-1:0] PERIPH_CLK_REQ,
    input wire logic KEY_PRESS,
    input wire logic USER_ACTIVITY,
    input wire logic BB_PKT_ACTIVE,
    input wire logic BB_TX,
    input wire logic BB_RX,
    input wire logic BB_LP_CONN,
    input wire logic BB_CONN_WAKE,
    output logic PERIPH_OSC_EN,
    output logic [NUM_PERIPH-1:0] PERIPH_CLK_GNT,
    output logic REGULATOR_OUTPUT_EN,
    output logic CORE_ISO,
    output logic LOW_POWER_OSC_SEL,
    output logic RADIO_TX_PD,
    output logic RADIO_RX_PD,
    output logic RADIO_PLL_PD,
    output logic RADIO_PA_PD,
    output logic [2:0] POWER_MODE
);
    import pwr_seq_pkg::*;

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    localparam int NS = NUM_PERIPH + 7;
    logic [NS-1:0] s1_q, s2_q;
    logic [NS-1:0] raw;
    assign raw = {BB_CONN_WAKE, BB_LP_CONN, BB_RX, BB_TX, BB_PKT_ACTIVE,
                  USER_ACTIVITY, KEY_PRESS, PERIPH_CLK_REQ};
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            s1_q <= '0;
            s2_q <= '0;
        end else begin
            s1_q <= raw;
            s2_q <= s1_q;
        end
    end
    logic [NUM_PERIPH-1:0] req_s;
    logic key_s, act_s, pkt_s, tx_s, rx_s, lpc_s, cwake_s;
    assign req_s = s2_q[NUM_PERIPH-1:0];
    assign {cwake_s, lpc_s, rx_s, tx_s, pkt_s, act_s, key_s} =
        s2_q[NS-1:NUM_PERIPH];

    // ------------------------------------------------------------
    // AHB-Lite slave
    // ------------------------------------------------------------
    logic [31:0] ctrl_q, ctrl_d, idle_q, idle_d, sleep_q, sleep_d;
    logic [31:0] off_q, off_d, wint_q, wint_d;
    logic [3:0] rpd_sw_q, rpd_sw_d;
    logic [NUM_PERIPH-1:0] pen_q, pen_d;
    logic wr_pend_q, wr_pend_d;
    logic [7:0] addr_q, addr_d;
    logic [31:0] rdata_q, rdata_d;
    logic sw_kick;
    logic take;
    assign take = HSEL && HREADY && (HTRANS == HTRANS_NONSEQ);

    function automatic logic [31:0] read_mux(input logic [7:0] a,
                                              input logic [31:0] st);
        unique case (a)
            CTRL_ADDR: read_mux = ctrl_q;
            IDLE_TMO_ADDR: read_mux = idle_q;
            SLEEP_TMO_ADDR: read_mux = sleep_q;
            OFF_TMO_ADDR: read_mux = off_q;
            WAKE_INT_ADDR: read_mux = wint_q;
            STATUS_ADDR: read_mux = st;
            RADIO_ADDR: read_mux = {28'h0000000, rpd_sw_q};
            PERIPH_EN_ADDR: read_mux = 32'(pen_q);
            default: read_mux = 32'h0000_0000;
        endcase
    endfunction

    pmode_e mode_q, mode_d;
    logic [31:0] status;
    logic [3:0] rpd_q;

    always_comb begin
        ctrl_d = ctrl_q;
        idle_d = idle_q;
        sleep_d = sleep_q;
        off_d = off_q;
        wint_d = wint_q;
        rpd_sw_d = rpd_sw_q;
        pen_d = pen_q;
        wr_pend_d = take && HWRITE;
        addr_d = take ? HADDR[7:0] : addr_q;
        rdata_d = take && !HWRITE ? read_mux(HADDR[7:0], status) : rdata_q;
        sw_kick = 1'b0;
        if (wr_pend_q) begin
            unique case (addr_q)
                CTRL_ADDR: begin
                    ctrl_d = HWDATA;
                    sw_kick = HWDATA[CTRL_FORCE_BIT] | HWDATA[CTRL_WAKE_BIT];
                end
                IDLE_TMO_ADDR: idle_d = HWDATA;
                SLEEP_TMO_ADDR: sleep_d = HWDATA;
                OFF_TMO_ADDR: off_d = HWDATA;
                WAKE_INT_ADDR: wint_d = HWDATA;
                RADIO_ADDR: rpd_sw_d = HWDATA[3:0];
                PERIPH_EN_ADDR: pen_d = HWDATA[NUM_PERIPH-1:0];
                default: ;
            endcase
            // Force and wake are one-shot commands
            ctrl_d[CTRL_FORCE_BIT] = 1'b0;
            ctrl_d[CTRL_WAKE_BIT] = 1'b0;
        end
    end

    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            ctrl_q <= CTRL_RST;
            idle_q <= IDLE_TMO_RST;
            sleep_q <= SLEEP_TMO_RST;
            off_q <= OFF_TMO_RST;
            wint_q <= WAKE_INT_RST;
            rpd_sw_q <= '0;
            pen_q <= '0;
            wr_pend_q <= 1'b0;
            addr_q <= '0;
            rdata_q <= '0;
        end else begin
            ctrl_q <= ctrl_d;
            idle_q <= idle_d;
            sleep_q <= sleep_d;
            off_q <= off_d;
            wint_q <= wint_d;
            rpd_sw_q <= rpd_sw_d;
            pen_q <= pen_d;
            wr_pend_q <= wr_pend_d;
            addr_q <= addr_d;
            rdata_q <= rdata_d;
        end
    end

    // ------------------------------------------------------------
    // Power mode state machine
    // ------------------------------------------------------------
    logic [31:0] cnt_q, cnt_d;
    logic wake_ev;
    // Key press counts as user activity so the scanner can wake the chip
    assign wake_ev = act_s | key_s;
    assign status = {24'h000000, 1'b0, lpc_s, 3'(mode_q), ~REGULATOR_OUTPUT_EN,
                     PERIPH_OSC_EN, 1'b0};

    always_comb begin
        mode_d = mode_q;
        cnt_d = cnt_q + 32'h0000_0001;
        unique case (mode_q)
            MODE_ACTIVE: if (cnt_q >= idle_q) begin
                mode_d = MODE_IDLE;
                cnt_d = '0;
            end
            MODE_IDLE: if (cnt_q >= sleep_q) begin
                mode_d = MODE_SLEEP;
                cnt_d = '0;
            end
            MODE_SLEEP: if (cnt_q >= off_q) begin
                mode_d = ctrl_q[CTRL_TIMED_BIT] ? MODE_TIMED : MODE_OFF;
                cnt_d = '0;
            end
            MODE_OFF: cnt_d = '0;
            MODE_TIMED: if (cnt_q >= wint_q) begin
                mode_d = MODE_ACTIVE;
                cnt_d = '0;
            end
            default: begin
                mode_d = MODE_ACTIVE;
                cnt_d = '0;
            end
        endcase
        if (!ctrl_q[CTRL_AUTO_BIT] && mode_q != MODE_TIMED) begin
            cnt_d = '0;
        end
        if (sw_kick && ctrl_q[CTRL_FORCE_BIT] == 1'b0 &&
            HWDATA[CTRL_FORCE_BIT] && mode_q < MODE_OFF) begin
            mode_d = pmode_e'(mode_q + 3'h1);
            cnt_d = '0;
        end
        // Activity beats any timeout in the same cycle
        if (wake_ev || pkt_s || (sw_kick && HWDATA[CTRL_WAKE_BIT])) begin
            mode_d = MODE_ACTIVE;
            cnt_d = '0;
        end
    end

    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            mode_q <= MODE_ACTIVE;
            cnt_q <= '0;
        end else begin
            mode_q <= mode_d;
            cnt_q <= cnt_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    logic [NUM_PERIPH-1:0] gnt_d;
    logic [3:0] rpd_d;
    logic reg_on_d;
    always_comb begin
        gnt_d = req_s & pen_q;
        // Scanner may wake its request on a key press while enabled
        gnt_d[KSCAN_IDX] = pen_q[KSCAN_IDX] &
                           (req_s[KSCAN_IDX] | key_s);
        reg_on_d = !(mode_d == MODE_OFF || mode_d == MODE_TIMED);
        // Radio is on only while a packet is being sent or received
        rpd_d[RPD_TX] = rpd_sw_q[RPD_TX] | !(pkt_s & tx_s);
        rpd_d[RPD_RX] = rpd_sw_q[RPD_RX] | !(pkt_s & rx_s);
        rpd_d[RPD_PLL] = rpd_sw_q[RPD_PLL] | !pkt_s;
        rpd_d[RPD_PA] = rpd_sw_q[RPD_PA] | !(pkt_s & tx_s);
        if (!reg_on_d) begin
            rpd_d = 4'hF;
            gnt_d = '0;
        end
    end

    logic osc_q, reg_on_q, slow_osc_q, iso_q;
    logic [NUM_PERIPH-1:0] gnt_q;
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            osc_q <= 1'b0;
            gnt_q <= '0;
            reg_on_q <= 1'b1;
            iso_q <= 1'b0;
            slow_osc_q <= 1'b0;
            rpd_q <= 4'hF;
        end else begin
            osc_q <= |gnt_d;
            gnt_q <= gnt_d;
            reg_on_q <= reg_on_d;
            // Own flop so isolation never glitches against the regulator
            iso_q <= !reg_on_d;
            // Low-power connection runs on the slow clock until its wake
            slow_osc_q <= lpc_s & !cwake_s;
            rpd_q <= rpd_d;
        end
    end

    assign PERIPH_OSC_EN = osc_q;
    assign PERIPH_CLK_GNT = gnt_q;
    assign REGULATOR_OUTPUT_EN = reg_on_q;
    assign CORE_ISO = iso_q;
    assign LOW_POWER_OSC_SEL = slow_osc_q;
    assign {RADIO_PA_PD, RADIO_PLL_PD, RADIO_RX_PD, RADIO_TX_PD} = rpd_q;
    assign POWER_MODE = mode_q;
    assign HRDATA = rdata_q;
    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_osc;
        @(posedge REF_CLK) disable iff (!RESETN)
        PERIPH_OSC_EN == (|PERIPH_CLK_GNT);
    endproperty
    a_osc: assert property (p_osc) else $error("osc off with grant");
    property p_dis;
        @(posedge REF_CLK) disable iff (!RESETN)
        (PERIPH_CLK_GNT & ~$past(pen_q)) == '0;
    endproperty
    a_dis: assert property (p_dis) else $error("grant when off");
    property p_iso;
        @(posedge REF_CLK) disable iff (!RESETN)
        CORE_ISO == !REGULATOR_OUTPUT_EN;
    endproperty
    a_iso: assert property (p_iso) else $error("iso mismatch");
    property p_wake;
        @(posedge REF_CLK) disable iff (!RESETN)
        act_s |=> mode_q == MODE_ACTIVE;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake");
    property p_reg;
        @(posedge REF_CLK) disable iff (!RESETN)
        mode_q == MODE_OFF |-> !REGULATOR_OUTPUT_EN;
    endproperty
    a_reg: assert property (p_reg) else $error("regulator on");
    property p_step;
        @(posedge REF_CLK) disable iff (!RESETN)
        mode_q == MODE_ACTIVE && !wake_ev && !pkt_s && !sw_kick &&
        ctrl_q[CTRL_AUTO_BIT] && cnt_q >= idle_q |=> mode_q == MODE_IDLE;
    endproperty
    a_step: assert property (p_step) else $error("no step");
    property p_radio;
        @(posedge REF_CLK) disable iff (!RESETN)
        !pkt_s |=> RADIO_PLL_PD;
    endproperty
    a_radio: assert property (p_radio) else $error("pll on");
endmodule // power_mode_sequencer

// ==== dv/pwr_far_side_model.sv ====
module pwr_far_side_model #(
    parameter int N = 4,
    parameter int KSCAN = 0
) (
    input wire logic clk,
    input wire logic [N-1:0] en,
    input wire logic [N-1:0] want,
    input wire logic rogue,
    input wire logic key,
    input wire logic pkt_go,
    input wire logic pkt_tx,
    input wire logic slow,
    output logic [N-1:0] req,
    output logic key_press,
    output logic bb_pkt,
    output logic bb_tx,
    output logic bb_rx
);
    timeunit 1ns;
    timeprecision 1ns;
    int left = 0;
    // ----------------------------------------
    // Peripherals; rogue only for masking tests
    // ----------------------------------------
    always_comb begin
        req = rogue ? want : (want & en);
        if (!rogue) begin
            req[KSCAN] = en[KSCAN] & (want[KSCAN] | key);
        end
    end
    assign key_press = key;
    // Baseband packet handler: radio only on inside a packet
    always @(posedge clk) begin
        if (pkt_go && left == 0) begin
            left <= slow ? 40 : 8;
        end else if (left > 0) begin
            left <= left - 1;
        end
    end
    assign bb_pkt = (left != 0);
    assign bb_tx = bb_pkt & pkt_tx;
    assign bb_rx = bb_pkt & !pkt_tx;
endmodule // pwr_far_side_model

// ==== dv/power_mode_sequencer_test.sv ====
module power_mode_sequencer_test;
    import pwr_seq_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic REF_CLK = 0, RESETN = 0, HSEL = 0, HWRITE = 0;
    logic [31:0] HADDR = '0, HWDATA = '0, HRDATA, r;
    logic [1:0] HTRANS = '0;
    logic HREADYOUT, HRESP, key = 0, act_q = 0, lpc = 0, cw = 0;
    logic [3:0] en = '0, want = '0, req, GNT, pd;
    logic rogue = 0, pkt_go = 0, pkt_tx = 0, slow = 0;
    logic kp, pkt, btx, brx, osc, reg_en, iso, los, txp, rxp, pllp, pap;
    logic [2:0] mode;
    int fails = 0, tests_run = 0;
    logic [7:0] ra [8] = '{CTRL_ADDR, IDLE_TMO_ADDR, SLEEP_TMO_ADDR,
        OFF_TMO_ADDR, WAKE_INT_ADDR, STATUS_ADDR, PERIPH_EN_ADDR, 8'h20};
    logic [31:0] rv [8] = '{CTRL_RST, IDLE_TMO_RST, SLEEP_TMO_RST,
        OFF_TMO_RST, WAKE_INT_RST, 32'h0, 32'h0, 32'h0};
    assign pd = {pap, pllp, rxp, txp};
    always #5 REF_CLK = ~REF_CLK;
    power_mode_sequencer power_mode_sequencer_i (.REF_CLK, .RESETN, .HSEL,
        .HADDR, .HTRANS, .HWRITE, .HSIZE(HSIZE_WORD), .HWDATA,
        .HREADY(HREADYOUT), .HRDATA, .HREADYOUT, .HRESP,
        .PERIPH_CLK_REQ(req), .KEY_PRESS(kp), .USER_ACTIVITY(act_q),
        .BB_PKT_ACTIVE(pkt), .BB_TX(btx), .BB_RX(brx), .BB_LP_CONN(lpc),
        .BB_CONN_WAKE(cw), .PERIPH_OSC_EN(osc), .PERIPH_CLK_GNT(GNT),
        .REGULATOR_OUTPUT_EN(reg_en), .CORE_ISO(iso),
        .LOW_POWER_OSC_SEL(los), .RADIO_TX_PD(txp), .RADIO_RX_PD(rxp),
        .RADIO_PLL_PD(pllp), .RADIO_PA_PD(pap), .POWER_MODE(mode));
    pwr_far_side_model pwr_far_side_model_i (.clk(REF_CLK), .en, .want,
        .rogue, .key, .pkt_go, .pkt_tx, .slow, .req, .key_press(kp),
        .bb_pkt(pkt), .bb_tx(btx), .bb_rx(brx));
    // ----------------------------------------
    // Bus and check helpers
    // ----------------------------------------
    task automatic cy(input int n);
        repeat (n) @(posedge REF_CLK);
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e,
                       input string s);
        tests_run++;
        if (g !== e) begin
            fails++;
            $display("ERROR %0t %s got %h", $time, s, g);
        end
    endtask
    // Zero wait states today, but the master still waits on ready
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge REF_CLK);
        HSEL <= 1'b1;
        HADDR <= {24'h0, a};
        HTRANS <= HTRANS_NONSEQ;
        HWRITE <= w;
        do @(posedge REF_CLK); while (HREADYOUT !== 1'b1);
        HSEL <= 1'b0;
        HTRANS <= 2'h0;
        HWDATA <= d;
        do @(posedge REF_CLK); while (HREADYOUT !== 1'b1);
        r = HRDATA;
    endtask
    task automatic wm(input logic [2:0] m, input string s);
        int k;
        k = 0;
        while (mode !== m && k < 300) begin
            @(posedge REF_CLK);
            k++;
        end
        chk({29'h0, mode}, {29'h0, m}, s);
    endtask
    task automatic act();
        act_q <= 1'b1;
        cy(2);
        act_q <= 1'b0;
    endtask
    task automatic pk(input logic tx, input logic [3:0] e, input string s);
        pkt_tx <= tx;
        pkt_go <= 1'b1;
        cy(1);
        pkt_go <= 1'b0;
        cy(5);
        chk({28'h0, pd}, {28'h0, e}, s);
        cy(45);
        chk({28'h0, pd}, 32'hF, "radio idle");
    endtask
    task automatic end_sim();
        $display("tests_run=%0d fails=%0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        #200000;
        fails++;
        end_sim();
    end
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        cy(10);
        RESETN <= 1'b1;
        chk({GNT, mode, reg_en, iso, los, pd, osc, HREADYOUT, HRESP},
            32'h27A, "reset outputs");
        bus(1'b1, 8'h20, 32'hFFFF_FFFF);
        for (int i = 0; i < 8; i++) begin
            bus(1'b0, ra[i], 32'h0);
            chk(r, rv[i], "reg reset");
        end
        $display("test registers done");
        bus(1'b1, CTRL_ADDR, 32'h0);
        bus(1'b1, PERIPH_EN_ADDR, 32'h6);
        en <= 4'h6;
        want <= 4'hF;
        rogue <= 1'b1;
        cy(5);
        chk({27'h0, GNT, osc}, 32'hD, "masked grants");
        rogue <= 1'b0;
        want <= 4'h0;
        cy(5);
        chk({27'h0, GNT, osc}, 32'h0, "osc stop");
        bus(1'b1, PERIPH_EN_ADDR, 32'h1);
        en <= 4'h1;
        key <= 1'b1;
        cy(5);
        chk({27'h0, GNT, osc}, 32'h3, "key grant");
        key <= 1'b0;
        want <= 4'h1;
        $display("test peripheral clock done");
        slow <= 1'b1;
        pk(1'b1, 4'b0010, "tx packet");
        pk(1'b0, 4'b1001, "rx packet");
        bus(1'b1, RADIO_ADDR, 32'h1);
        slow <= 1'b0;
        pk(1'b1, 4'b0011, "sw tx pd");
        bus(1'b1, RADIO_ADDR, 32'h0);
        lpc <= 1'b1;
        cy(5);
        chk({31'h0, los}, 32'h1, "lp osc");
        cw <= 1'b1;
        cy(5);
        chk({31'h0, los}, 32'h0, "lp wake");
        lpc <= 1'b0;
        cw <= 1'b0;
        $display("test radio done");
        bus(1'b1, CTRL_ADDR, 32'h4);
        wm(3'd1, "force step");
        bus(1'b1, CTRL_ADDR, 32'h8);
        wm(3'd0, "wake cmd");
        for (int i = 1; i < 4; i++) begin
            bus(1'b1, ra[i], 32'h14);
        end
        bus(1'b1, CTRL_ADDR, 32'h1);
        act();
        cy(12);
        chk({29'h0, mode}, 32'h0, "early step");
        wm(3'd1, "to idle");
        wm(3'd2, "to sleep");
        wm(3'd3, "to off");
        chk({22'h0, reg_en, iso, GNT, pd}, 32'h10F, "off domain");
        bus(1'b0, STATUS_ADDR, 32'h0);
        chk({28'h0, r[5:2]}, 32'h7, "status off");
        act_q <= 1'b1;
        cy(4);
        chk({28'h0, mode, reg_en}, 32'h1, "user wake");
        act_q <= 1'b0;
        $display("test deep off done");
        bus(1'b1, WAKE_INT_ADDR, 32'd30);
        bus(1'b1, CTRL_ADDR, 32'h3);
        act();
        wm(3'd4, "to timed");
        chk({31'h0, reg_en}, 32'h0, "timed off");
        wm(3'd0, "timer wake");
        $display("test timed sleep done");
        end_sim();
    end
endmodule // power_mode_sequencer_test
